// ### src/drt_defs.vh
/*
  Constants for the dual-mode reload timer: register addresses on the
  special-function-register bus, control bit positions, reset values and
  prescaler counts.
  Assumes it is included by bare name from each design file.
*/
// Functional notes
// - Split bit picks 16-bit or two 8-bit counters
// - Run bit 1 counts, 0 stops
// - Split mode: run bit gates high byte only
// - Control bit 1 reads zero, writes ignored
// - External select 0: core clock divided by 12
// - External select 1: synchronised oscillator divided by 8
// - One external select serves both split bytes
// - Per-byte fast select picks core or divided source
// - Reload low byte: read/write, reset zero, low reload
// - Reload high byte: read/write, reset zero, high reload
// - 16-bit mode: count low is low count byte
// - Split mode: count low is whole low counter
// - Wrap reloads counter; 16-bit wrap sets high flag
// - Low wrap sets low flag; only software clears
// - Interrupt follows high flag, low flag when enabled
// - Fast select 1 core clock, 0 divided source
`ifndef DRT_DEFS_VH
`define DRT_DEFS_VH

`define DRT_ADDR_CTRL 8'hc8
`define DRT_ADDR_CLKSEL 8'hc9
`define DRT_ADDR_RLD_LO 8'hca
`define DRT_ADDR_RLD_HI 8'hcb
`define DRT_ADDR_CNT_LO 8'hcc
`define DRT_ADDR_CNT_HI 8'hcd

`define DRT_BIT_HIGH_OVF 7
`define DRT_BIT_LOW_OVF 6
`define DRT_BIT_LOW_IRQ_EN 5
`define DRT_BIT_SPLIT 3
`define DRT_BIT_RUN 2
`define DRT_BIT_EXT_SEL 0

`define DRT_BIT_HIGH_FAST 5
`define DRT_BIT_LOW_FAST 4

`define DRT_RST_BYTE 8'h00
`define DRT_BYTE_MAX 8'hff

`define DRT_CORE_DIV 12
`define DRT_EXT_DIV 8

`endif

// ### src/drt_tick_gen.v
/*
  Count-source generator: core clock divided by 12, or an external
  oscillator synchronised and divided by 8, as a one-cycle tick.
  Assumes ext_osc is asynchronous and much slower than half of sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "drt_defs.vh"

module drt_tick_gen
(
  input wire sys_clk, // Core clock
  input wire srst, // Synchronous reset, active high
  input wire ext_osc, // External oscillator pin, asynchronous
  input wire ext_source_select, // 1 selects oscillator divided by 8
  output reg div_tick_r // One-cycle tick of the selected source
);

  localparam [31:0] CORE_LAST_W = `DRT_CORE_DIV - 1;
  localparam [31:0] EXT_LAST_W = `DRT_EXT_DIV - 1;
  // Cut to the counter widths on purpose
  localparam [3:0] CORE_LAST = CORE_LAST_W[3:0];
  localparam [2:0] EXT_LAST = EXT_LAST_W[2:0];

  reg [3:0] core_cnt_r;
  reg osc_meta_r;
  reg osc_sync_r;
  reg osc_prev_r;
  reg [2:0] ext_cnt_r;
  wire core_tick;
  wire osc_rise;
  wire ext_tick;

  assign core_tick = (core_cnt_r == CORE_LAST);
  assign osc_rise = osc_sync_r & ~osc_prev_r;
  assign ext_tick = osc_rise & (ext_cnt_r == EXT_LAST);

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      core_cnt_r <= 4'h0;
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_prev_r <= 1'b0;
      ext_cnt_r <= 3'h0;
      div_tick_r <= 1'b0;
    end
    else
    begin
      core_cnt_r <= core_tick ? 4'h0 : core_cnt_r + 4'h1;
      // Two flops before anything looks at the pin
      osc_meta_r <= ext_osc;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
      if (osc_rise)
        ext_cnt_r <= ext_cnt_r + 3'h1;
      // Both bytes share this one selected tick
      div_tick_r <= ext_source_select ? ext_tick : core_tick;
    end
  end

endmodule
`default_nettype wire

// ### src/drt_byte_counter.v
/*
  One 8-bit counter byte with reload and software write.
  Assumes the caller decides when the byte increments and reloads.
*/
`timescale 1ns/100ps
`default_nettype none
`include "drt_defs.vh"

module drt_byte_counter
(
  input wire sys_clk, // Core clock
  input wire srst, // Synchronous reset, active high
  input wire inc, // Increment this cycle
  input wire load, // Reload this cycle
  input wire [7:0] reload_val, // Value taken on reload
  input wire wr, // Software write strobe
  input wire [7:0] wdata, // Software write data
  output reg [7:0] cnt_r, // Current count
  output wire at_max // Count is all ones
);

  assign at_max = (cnt_r == `DRT_BYTE_MAX);

  always @(posedge sys_clk)
  begin
    if (srst)
      cnt_r <= `DRT_RST_BYTE;
    else if (wr)
      cnt_r <= wdata;
    else if (load)
      cnt_r <= reload_val;
    else if (inc)
      cnt_r <= cnt_r + 8'h01;
  end

endmodule
`default_nettype wire

// ### src/drt_timer.v
/*
  Dual-mode reload timer: one 16-bit auto-reload counter or two 8-bit
  auto-reload counters, with control, clock-select, reload and count
  registers on the special-function-register bus.
  Assumes a single-cycle bus: sfr_wr and sfr_rd are one-cycle strobes
  from logic on sys_clk, never both at once.
*/
`timescale 1ns/100ps
`default_nettype none
`include "drt_defs.vh"

module drt_timer
(
  input wire sys_clk, // Core clock
  input wire srst, // Synchronous reset, active high
  input wire [7:0] sfr_addr, // Register address
  input wire sfr_wr, // Write strobe
  input wire sfr_rd, // Read strobe
  input wire [7:0] sfr_wdata, // Write data
  output reg [7:0] sfr_rdata_r, // Read data, one cycle after sfr_rd
  input wire ext_osc, // External oscillator pin
  input wire timer_irq_enable, // Timer interrupt enable from core
  output wire timer_irq_req // Interrupt request level
);

  reg high_overflow_flag_r;
  reg low_overflow_flag_r;
  reg low_overflow_irq_enable_r;
  reg split_mode_select_r;
  reg high_run_control_r;
  reg ext_source_select_r;
  reg high_byte_fast_clock_sel_r;
  reg low_byte_fast_clock_sel_r;
  reg [7:0] reload_value_low_r;
  reg [7:0] reload_value_high_r;

  wire div_tick;
  wire low_tick;
  wire high_tick;
  wire low_inc;
  wire low_wrap;
  wire low_load;
  wire high_inc;
  wire high_wrap;
  wire [7:0] count_value_low;
  wire [7:0] count_value_high;
  wire low_at_max;
  wire high_at_max;
  wire wr_ctrl;
  wire wr_clksel;
  wire wr_cnt_lo;
  wire wr_cnt_hi;
  wire [7:0] ctrl_rd;
  reg [7:0] rdata_nxt;

  assign wr_ctrl = sfr_wr & (sfr_addr == `DRT_ADDR_CTRL);
  assign wr_clksel = sfr_wr & (sfr_addr == `DRT_ADDR_CLKSEL);
  assign wr_cnt_lo = sfr_wr & (sfr_addr == `DRT_ADDR_CNT_LO);
  assign wr_cnt_hi = sfr_wr & (sfr_addr == `DRT_ADDR_CNT_HI);

  drt_tick_gen u_tick
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .ext_osc(ext_osc),
    .ext_source_select(ext_source_select_r),
    .div_tick_r(div_tick)
  );

  // Fast select takes the core clock, otherwise the divided tick
  assign low_tick = low_byte_fast_clock_sel_r | div_tick;
  assign high_tick = high_byte_fast_clock_sel_r | div_tick;

  // Low byte free-runs in split mode; run bit gates it in 16-bit mode
  assign low_inc = split_mode_select_r ? low_tick :
                   (high_run_control_r & low_tick);
  assign low_wrap = low_inc & low_at_max;
  // 16-bit mode chains the high byte off the low carry
  assign high_inc = split_mode_select_r ?
                    (high_run_control_r & high_tick) :
                    low_wrap;
  assign high_wrap = high_inc & high_at_max;
  // Split: low reloads on its own wrap; 16-bit: only on 0xFFFF wrap
  assign low_load = split_mode_select_r ? low_wrap :
                    (low_wrap & high_at_max);

  drt_byte_counter u_low
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .inc(low_inc),
    .load(low_load),
    .reload_val(reload_value_low_r),
    .wr(wr_cnt_lo),
    .wdata(sfr_wdata),
    .cnt_r(count_value_low),
    .at_max(low_at_max)
  );

  drt_byte_counter u_high
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .inc(high_inc),
    .load(high_wrap),
    .reload_val(reload_value_high_r),
    .wr(wr_cnt_hi),
    .wdata(sfr_wdata),
    .cnt_r(count_value_high),
    .at_max(high_at_max)
  );

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      low_overflow_irq_enable_r <= 1'b0;
      split_mode_select_r <= 1'b0;
      high_run_control_r <= 1'b0;
      ext_source_select_r <= 1'b0;
      high_byte_fast_clock_sel_r <= 1'b0;
      low_byte_fast_clock_sel_r <= 1'b0;
      reload_value_low_r <= `DRT_RST_BYTE;
      reload_value_high_r <= `DRT_RST_BYTE;
    end
    else
    begin
      if (wr_ctrl)
      begin
        // Bits 4 and 1 have no storage at all
        low_overflow_irq_enable_r <= sfr_wdata[`DRT_BIT_LOW_IRQ_EN];
        split_mode_select_r <= sfr_wdata[`DRT_BIT_SPLIT];
        high_run_control_r <= sfr_wdata[`DRT_BIT_RUN];
        ext_source_select_r <= sfr_wdata[`DRT_BIT_EXT_SEL];
      end
      if (wr_clksel)
      begin
        high_byte_fast_clock_sel_r <= sfr_wdata[`DRT_BIT_HIGH_FAST];
        low_byte_fast_clock_sel_r <= sfr_wdata[`DRT_BIT_LOW_FAST];
      end
      if (sfr_wr & (sfr_addr == `DRT_ADDR_RLD_LO))
        reload_value_low_r <= sfr_wdata;
      if (sfr_wr & (sfr_addr == `DRT_ADDR_RLD_HI))
        reload_value_high_r <= sfr_wdata;
    end
  end

  // Flags: a hardware set in the same cycle as a software clear wins
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      high_overflow_flag_r <= 1'b0;
      low_overflow_flag_r <= 1'b0;
    end
    else
    begin
      if (high_wrap)
        high_overflow_flag_r <= 1'b1;
      else if (wr_ctrl)
        high_overflow_flag_r <= sfr_wdata[`DRT_BIT_HIGH_OVF];
      if (low_wrap)
        low_overflow_flag_r <= 1'b1;
      else if (wr_ctrl)
        low_overflow_flag_r <= sfr_wdata[`DRT_BIT_LOW_OVF];
    end
  end

  assign timer_irq_req = timer_irq_enable &
    (high_overflow_flag_r |
     (low_overflow_irq_enable_r & low_overflow_flag_r));

  // Unused bits 4 and 1 read as zero
  assign ctrl_rd = {high_overflow_flag_r, low_overflow_flag_r,
                    low_overflow_irq_enable_r, 1'b0,
                    split_mode_select_r, high_run_control_r,
                    1'b0, ext_source_select_r};

  always @*
  begin
    rdata_nxt = 8'h00;
    case (sfr_addr)
      `DRT_ADDR_CTRL: rdata_nxt = ctrl_rd;
      `DRT_ADDR_CLKSEL:
      begin
        rdata_nxt[`DRT_BIT_HIGH_FAST] = high_byte_fast_clock_sel_r;
        rdata_nxt[`DRT_BIT_LOW_FAST] = low_byte_fast_clock_sel_r;
      end
      `DRT_ADDR_RLD_LO: rdata_nxt = reload_value_low_r;
      `DRT_ADDR_RLD_HI: rdata_nxt = reload_value_high_r;
      `DRT_ADDR_CNT_LO: rdata_nxt = count_value_low;
      `DRT_ADDR_CNT_HI: rdata_nxt = count_value_high;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data holds until the next read
  always @(posedge sys_clk)
  begin
    if (srst)
      sfr_rdata_r <= 8'h00;
    else if (sfr_rd)
      sfr_rdata_r <= rdata_nxt;
  end

endmodule
`default_nettype wire

// ### bench/drt_timer_chk.sv
/*
  Port checker for drt_timer: bus answers, reset state, interrupt request.
  Assumes it is bound to drt_timer and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module drt_timer_chk
(
  input wire sys_clk, // Core clock
  input wire srst, // Synchronous reset
  input wire [7:0] sfr_addr, // Register address
  input wire sfr_wr, // Write strobe
  input wire sfr_rd, // Read strobe
  input wire [7:0] sfr_wdata, // Write data
  input wire [7:0] sfr_rdata_r, // Read data
  input wire ext_osc, // Oscillator pin
  input wire timer_irq_enable, // Interrupt enable
  input wire timer_irq_req // Interrupt request
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  rst_clears_a: assert property (disable iff (1'b0)
    srst |=> sfr_rdata_r == 8'h00 && !timer_irq_req)
    else $error("reset left read data or request set");
  irq_gated_a: assert property (!timer_irq_enable |-> !timer_irq_req)
    else $error("request without enable");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata_r))
    else $error("read data moved without a read");
  unused_zero_a: assert property (sfr_rd && sfr_addr == 8'hc8 |=>
    sfr_rdata_r[4] == 1'b0 && sfr_rdata_r[1] == 1'b0)
    else $error("unused control bits read nonzero");
  unmapped_zero_a: assert property (sfr_rd &&
    (sfr_addr < 8'hc8 || sfr_addr > 8'hcd) |=> sfr_rdata_r == 8'h00)
    else $error("unmapped read nonzero");
  rld_lo_a: assert property (sfr_wr && sfr_addr == 8'hca ##1
    sfr_rd && sfr_addr == 8'hca |=> sfr_rdata_r == $past(sfr_wdata, 2))
    else $error("reload low readback wrong");
  rld_hi_a: assert property (sfr_wr && sfr_addr == 8'hcb ##1
    sfr_rd && sfr_addr == 8'hcb |=> sfr_rdata_r == $past(sfr_wdata, 2))
    else $error("reload high readback wrong");
  cnt_wins_a: assert property (sfr_wr && sfr_addr == 8'hcc ##1
    sfr_rd && sfr_addr == 8'hcc |=> sfr_rdata_r == $past(sfr_wdata, 2))
    else $error("count write lost to increment");
  flag_irq_a: assert property (sfr_wr && sfr_addr == 8'hc8 &&
    sfr_wdata[7] ##1 timer_irq_enable |-> timer_irq_req)
    else $error("high flag set but no request");
  flag_sticky_a: assert property (timer_irq_req &&
    !(sfr_wr && sfr_addr == 8'hc8) |=> timer_irq_req || !timer_irq_enable)
    else $error("flag cleared by hardware");
endmodule
bind drt_timer drt_timer_chk u_chk (.sys_clk, .srst, .sfr_addr, .sfr_wr,
  .sfr_rd, .sfr_wdata, .sfr_rdata_r, .ext_osc, .timer_irq_enable,
  .timer_irq_req);
`default_nettype wire

// ### bench/tb.sv
/*
  Self-checking bench for drt_timer: registers, 16-bit counting from the core
  clock, split counting from each source, flags and interrupt request.
  Assumes drt_defs.vh is on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic ext_osc = 1'b0;
  logic timer_irq_enable = 1'b0;
  wire [7:0] sfr_rdata_r;
  wire timer_irq_req;
  logic [31:0] seed = 32'h15af153a;
  logic [7:0] v;
  logic [7:0] w;
  logic [2:0] osc_div = 3'h0;
  int fails = 0;
  int n_checks = 0;

  always #12.5 sys_clk = ~sys_clk;
  // Oscillator at an eighth of the core clock, well below its half rate
  always @(negedge sys_clk)
  begin
    osc_div <= osc_div + 3'h1;
    if (osc_div[1:0] == 2'h3)
      ext_osc <= ~ext_osc;
  end

  drt_timer u_dut
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata_r(sfr_rdata_r),
    .ext_osc(ext_osc),
    .timer_irq_enable(timer_irq_enable),
    .timer_irq_req(timer_irq_req)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] ctrl_exp(input logic [7:0] d);
    return d & 8'hed;
  endfunction
  // Request follows high flag, or low flag when its enable is set
  function automatic logic [7:0] irq_exp(input logic [7:0] d,
    input logic en);
    return {7'h00, en & (d[7] | (d[6] & d[5]))};
  endfunction

  // Strobe is left high on return until the next rd or idle drops it, so back-to-back calls stay glitch free
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    sfr_rd = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic idle(input int n);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] lo,
    input logic [7:0] hi, input logic [7:0] g);
    n_checks++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      fails++;
      $display("BAD %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] lo,
    input logic [7:0] hi);
    sfr_addr = a;
    sfr_rd = 1'b1;
    sfr_wr = 1'b0;
    @(negedge sys_clk);
    v = sfr_rdata_r;
    chk($sformatf("reg %h", a), lo, hi, v);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (10000) @(posedge sys_clk);
    fails++;
    give_verdict;
  end

  initial
  begin
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    for (int a = 8'hc7; a <= 8'hce; a++)
      rd(a[7:0], 8'h00, 8'h00);
    rd(seed[7:0] & 8'h7f, 8'h00, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      w = seed[23:16];
      timer_irq_enable = seed[24];
      wr(8'hca, seed[7:0]);
      rd(8'hca, seed[7:0], seed[7:0]);
      wr(8'hcb, seed[15:8]);
      rd(8'hcb, seed[15:8], seed[15:8]);
      wr(8'hc8, w);
      rd(8'hc8, ctrl_exp(w), ctrl_exp(w));
      v = irq_exp(w, timer_irq_enable);
      chk("irq reg", v, v, {7'h00, timer_irq_req});
    end
    $display("test registers done");
    timer_irq_enable = 1'b1;
    wr(8'hc8, 8'h00);
    wr(8'hc9, 8'h10);
    rd(8'hc9, 8'h10, 8'h10);
    wr(8'hca, 8'h00);
    wr(8'hcb, 8'h12);
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hf8);
    wr(8'hc8, 8'h04);
    idle(20);
    rd(8'hcd, 8'h12, 8'h12);
    rd(8'hcc, 8'h08, 8'h20);
    rd(8'hc8, 8'hc4, 8'hc4);
    chk("irq", 8'h01, 8'h01, {7'h00, timer_irq_req});
    w = seed[31:24];
    wr(8'hcc, w);
    rd(8'hcc, w, w);
    wr(8'hc8, 8'h00);
    chk("irq clear", 8'h00, 8'h00, {7'h00, timer_irq_req});
    rd(8'hcc, 8'h00, 8'hff);
    w = v;
    idle(5);
    rd(8'hcc, w, w);
    $display("test sixteen bit done");
    wr(8'hc9, 8'h30);
    wr(8'hcd, 8'h55);
    wr(8'hc8, 8'h08);
    idle(300);
    rd(8'hcd, 8'h55, 8'h55);
    rd(8'hc8, 8'h48, 8'h48);
    wr(8'hc8, 8'h0c);
    idle(300);
    rd(8'hc8, 8'hcc, 8'hcc);
    wr(8'hca, 8'h40);
    wr(8'hcc, 8'hfe);
    idle(3);
    rd(8'hcc, 8'h40, 8'h43);
    $display("test split done");
    wr(8'hc9, 8'h10);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h0c);
    idle(120);
    rd(8'hcd, 8'd9, 8'd11);
    wr(8'hc9, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h0d);
    idle(640);
    rd(8'hcc, 8'd9, 8'd11);
    rd(8'hcd, 8'd9, 8'd11);
    $display("test sources done");
    idle(1);
    give_verdict;
  end
endmodule
`default_nettype wire
